/* src/tmr8w_pkg.sv */
// Package: register map, field layout and types of the 8-bit waveform timer
package tmr8w_pkg;
    localparam logic [7:0] off_mode_ctrl = 8'h30;
    localparam logic [7:0] off_ctrl_b = 8'h33;
    localparam logic [7:0] off_count = 8'h32;
    localparam logic [7:0] off_cmp_a = 8'h36;
    localparam logic [7:0] off_cmp_b = 8'h3c;
    localparam logic [7:0] off_irq_mask = 8'h39;
    localparam logic [7:0] off_irq_status = 8'h38;
    localparam int pos_out_a = 6;
    localparam int pos_out_b = 4;
    localparam int pos_wave_low = 0;
    localparam int pos_wave_high = 3;
    localparam int pos_flag_ovf = 0;
    localparam int pos_flag_a = 1;
    localparam int pos_flag_b = 2;
    localparam logic [7:0] mode_ctrl_rmask = 8'hf3;
    localparam logic [7:0] ctrl_b_rmask = 8'h0f;
    localparam logic [7:0] reset_byte = 8'h00;
    localparam logic [7:0] max_value = 8'hff;
    localparam logic [7:0] bottom_value = 8'h00;
    localparam logic [9:0] div_8 = 10'h007;
    localparam logic [9:0] div_64 = 10'h03f;
    localparam logic [9:0] div_256 = 10'h0ff;
    localparam logic [9:0] div_1024 = 10'h3ff;
    localparam logic [2:0] wm_normal = 3'h0;
    localparam logic [2:0] wm_pc_ff = 3'h1;
    localparam logic [2:0] wm_ctc = 3'h2;
    localparam logic [2:0] wm_fast_ff = 3'h3;
    localparam logic [2:0] wm_pc_a = 3'h5;
    localparam logic [2:0] wm_fast_a = 3'h7;

    typedef enum logic [1:0] {act_off, act_toggle, act_clear, act_set} tmr8w_action_type;

    typedef struct packed {
        logic toggle;
        logic clear;
        logic set;
    } tmr8w_wave_type;
endpackage

/* src/tmr8w_channel.sv */
// One compare channel: match detection, buffered compare value, output waveform
`timescale 1ns/10ps
module tmr8w_channel (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tick,
    input wire logic [2:0] wave_mode,
    input wire logic [1:0] action,
    input wire logic allow_toggle_pwm,
    input wire logic [7:0] count_value,
    input wire logic [7:0] top,
    input wire logic counting_down,
    input wire logic at_top,
    input wire logic at_bottom,
    input wire logic wr_cmp,
    input wire logic [7:0] wr_data,
    output logic [7:0] cmp_active,
    output logic [7:0] cmp_buffer,
    output logic match,
    output logic cmp_out
);
    logic [7:0] next_cmp_active;
    logic [7:0] next_cmp_buffer;
    logic next_cmp_out;
    logic fast;
    logic phase;
    logic ignore;

    always_comb
    begin
        fast = (wave_mode == tmr8w_pkg::wm_fast_ff) || (wave_mode == tmr8w_pkg::wm_fast_a);
        phase = (wave_mode == tmr8w_pkg::wm_pc_ff) || (wave_mode == tmr8w_pkg::wm_pc_a);
        match = tick && (count_value == cmp_active);
        ignore = (fast || phase) && action[1] && (cmp_active == top);
        next_cmp_buffer = wr_cmp ? wr_data : cmp_buffer;
        next_cmp_active = cmp_active;
        if (!(fast || phase))
        begin
            next_cmp_active = next_cmp_buffer;
        end
        else if (tick && ((phase && at_top) || (fast && at_bottom)))
        begin
            next_cmp_active = cmp_buffer;
        end
        next_cmp_out = cmp_out;
        if (!(fast || phase))
        begin
            if (match)
            begin
                case (action)
                    tmr8w_pkg::act_toggle: next_cmp_out = !cmp_out;
                    tmr8w_pkg::act_clear: next_cmp_out = 1'b0;
                    tmr8w_pkg::act_set: next_cmp_out = 1'b1;
                    default: next_cmp_out = cmp_out;
                endcase
            end
        end
        else if (action == tmr8w_pkg::act_toggle)
        begin
            if (match && allow_toggle_pwm)
            begin
                next_cmp_out = !cmp_out;
            end
        end
        else if (action[1])
        begin
            if (fast)
            begin
                if (match && !ignore)
                begin
                    next_cmp_out = action[0];
                end
                else if (tick && at_bottom)
                begin
                    next_cmp_out = !action[0];
                end
            end
            else if (ignore)
            begin
                if (tick && at_top)
                begin
                    // Top takes the down-count result, keeping the pulse symmetric
                    next_cmp_out = !action[0];
                end
            end
            else if (match)
            begin
                next_cmp_out = counting_down ? !action[0] : action[0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cmp_active <= tmr8w_pkg::reset_byte;
            cmp_buffer <= tmr8w_pkg::reset_byte;
            cmp_out <= 1'b0;
        end
        else
        begin
            cmp_active <= next_cmp_active;
            cmp_buffer <= next_cmp_buffer;
            cmp_out <= next_cmp_out;
        end
    end
endmodule

/* src/tmr8w_top.sv */
// Top: AHB-Lite registers, prescaler, counter, flags and pin override
`timescale 1ns/10ps
module tmr8w_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ext_clk_pin,
    output logic cmp_out_a,
    output logic cmp_out_b,
    output logic pin_a_override,
    output logic pin_b_override,
    output logic irq
);
    logic [7:0] mode_ctrl;
    logic [7:0] next_mode_ctrl;
    logic [3:0] ctrl_b;
    logic [3:0] next_ctrl_b;
    logic [7:0] count_value;
    logic [7:0] next_count_value;
    logic counting_down;
    logic next_counting_down;
    logic [2:0] irq_mask;
    logic [2:0] next_irq_mask;
    logic [2:0] irq_status;
    logic [2:0] next_irq_status;
    logic [9:0] prescale;
    logic [9:0] next_prescale;
    logic [2:0] ext_sync;
    logic wr_pend;
    logic next_wr_pend;
    logic [7:0] wr_addr;
    logic [7:0] next_wr_addr;
    logic [31:0] next_hrdata;
    logic next_cmp_out_a;
    logic next_cmp_out_b;
    logic next_pin_a;
    logic next_pin_b;
    logic next_irq;
    logic [2:0] wave_mode;
    logic [7:0] top;
    logic tick;
    logic at_top;
    logic at_bottom;
    logic match_a;
    logic match_b;
    logic chan_a_out;
    logic chan_b_out;
    logic [7:0] cmp_active_a;
    logic [7:0] cmp_buffer_a;
    logic [7:0] cmp_buffer_b;
    logic wr_cmp_a;
    logic wr_cmp_b;
    logic wr_count;
    logic ovf_event;
    logic fast;
    logic phase;
    logic addr_phase;
    logic [7:0] wdata;

    function automatic logic [7:0] read_reg(input logic [7:0] addr);
        case (addr)
            tmr8w_pkg::off_mode_ctrl: read_reg = mode_ctrl & tmr8w_pkg::mode_ctrl_rmask;
            tmr8w_pkg::off_ctrl_b: read_reg = {4'h0, ctrl_b};
            tmr8w_pkg::off_count: read_reg = count_value;
            tmr8w_pkg::off_cmp_a: read_reg = cmp_buffer_a;
            tmr8w_pkg::off_cmp_b: read_reg = cmp_buffer_b;
            tmr8w_pkg::off_irq_mask: read_reg = {5'h00, irq_mask};
            tmr8w_pkg::off_irq_status: read_reg = {5'h00, irq_status};
            default: read_reg = 8'h00;
        endcase
    endfunction

    // Write strobe for one register, live in the data phase only
    function automatic logic wr_hit(input logic [7:0] addr);
        wr_hit = wr_pend && (wr_addr == addr);
    endfunction

    function automatic logic [7:0] count_step(input logic [7:0] value, input logic down);
        count_step = down ? value - 8'h01 : value + 8'h01;
    endfunction

    tmr8w_channel chan_a (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick),
        .wave_mode(wave_mode),
        .action(mode_ctrl[tmr8w_pkg::pos_out_a +: 2]),
        .allow_toggle_pwm(wave_mode[2]),
        .count_value(count_value),
        .top(top),
        .counting_down(counting_down),
        .at_top(at_top),
        .at_bottom(at_bottom),
        .wr_cmp(wr_cmp_a),
        .wr_data(wdata),
        .cmp_active(cmp_active_a),
        .cmp_buffer(cmp_buffer_a),
        .match(match_a),
        .cmp_out(chan_a_out)
    );

    tmr8w_channel chan_b (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick),
        .wave_mode(wave_mode),
        .action(mode_ctrl[tmr8w_pkg::pos_out_b +: 2]),
        .allow_toggle_pwm(1'b0),
        .count_value(count_value),
        .top(top),
        .counting_down(counting_down),
        .at_top(at_top),
        .at_bottom(at_bottom),
        .wr_cmp(wr_cmp_b),
        .wr_data(wdata),
        .cmp_active(),
        .cmp_buffer(cmp_buffer_b),
        .match(match_b),
        .cmp_out(chan_b_out)
    );

    always_comb
    begin
        wave_mode = {ctrl_b[tmr8w_pkg::pos_wave_high], mode_ctrl[tmr8w_pkg::pos_wave_low +: 2]};
        fast = (wave_mode == tmr8w_pkg::wm_fast_ff) || (wave_mode == tmr8w_pkg::wm_fast_a);
        phase = (wave_mode == tmr8w_pkg::wm_pc_ff) || (wave_mode == tmr8w_pkg::wm_pc_a);
        // Reserved modes 4 and 6 behave as normal counting with top at max
        case (wave_mode)
            tmr8w_pkg::wm_ctc, tmr8w_pkg::wm_pc_a, tmr8w_pkg::wm_fast_a: top = cmp_active_a;
            default: top = tmr8w_pkg::max_value;
        endcase
        at_top = (count_value == top);
        at_bottom = (count_value == tmr8w_pkg::bottom_value);
        case (ctrl_b[2:0])
            3'h1: tick = 1'b1;
            3'h2: tick = (prescale & tmr8w_pkg::div_8) == tmr8w_pkg::div_8;
            3'h3: tick = (prescale & tmr8w_pkg::div_64) == tmr8w_pkg::div_64;
            3'h4: tick = (prescale & tmr8w_pkg::div_256) == tmr8w_pkg::div_256;
            3'h5: tick = prescale == tmr8w_pkg::div_1024;
            3'h6: tick = ext_sync[2] && !ext_sync[1];
            3'h7: tick = !ext_sync[2] && ext_sync[1];
            default: tick = 1'b0;
        endcase
        // Held at zero while stopped, so the first divided tick is a full period
        next_prescale = (ctrl_b[2:0] == 3'h0) ? 10'h000 : prescale + 10'h001;
        addr_phase = hsel && hready && htrans[1];
        wdata = hwdata[7:0];
        wr_cmp_a = wr_hit(tmr8w_pkg::off_cmp_a);
        wr_cmp_b = wr_hit(tmr8w_pkg::off_cmp_b);
        wr_count = wr_hit(tmr8w_pkg::off_count);
        next_wr_pend = addr_phase && hwrite;
        next_wr_addr = haddr[7:0];
        // Read sampled in the address phase: a write still in flight is not seen
        next_hrdata = (addr_phase && !hwrite) ? {24'h000000, read_reg(haddr[7:0])} : 32'h0;
        next_mode_ctrl = mode_ctrl;
        next_ctrl_b = ctrl_b;
        next_irq_mask = irq_mask;
        if (wr_hit(tmr8w_pkg::off_mode_ctrl))
        begin
            next_mode_ctrl = wdata & tmr8w_pkg::mode_ctrl_rmask;
        end
        if (wr_hit(tmr8w_pkg::off_ctrl_b))
        begin
            next_ctrl_b = wdata[3:0];
        end
        if (wr_hit(tmr8w_pkg::off_irq_mask))
        begin
            next_irq_mask = wdata[2:0];
        end
        next_count_value = count_value;
        next_counting_down = counting_down;
        // Software count write wins over a tick in the same cycle
        if (wr_count)
        begin
            next_count_value = wdata;
        end
        else if (tick)
        begin
            if (phase)
            begin
                if (at_top)
                begin
                    next_counting_down = 1'b1;
                    next_count_value = count_step(count_value, 1'b1);
                end
                else if (at_bottom)
                begin
                    next_counting_down = 1'b0;
                    next_count_value = count_step(count_value, 1'b0);
                end
                else
                begin
                    next_count_value = count_step(count_value, counting_down);
                end
            end
            else if ((fast || wave_mode == tmr8w_pkg::wm_ctc) && at_top)
            begin
                next_count_value = tmr8w_pkg::bottom_value;
            end
            else
            begin
                next_count_value = count_step(count_value, 1'b0);
            end
        end
        if (!phase)
        begin
            next_counting_down = 1'b0;
        end
        case (wave_mode)
            tmr8w_pkg::wm_pc_ff, tmr8w_pkg::wm_pc_a: ovf_event = tick && at_bottom;
            tmr8w_pkg::wm_fast_a: ovf_event = tick && at_top;
            default: ovf_event = tick && (count_value == tmr8w_pkg::max_value);
        endcase
        next_irq_status = irq_status;
        if (wr_hit(tmr8w_pkg::off_irq_status))
        begin
            next_irq_status = irq_status & ~wdata[2:0];
        end
        // Set beats a simultaneous write-one clear
        next_irq_status[tmr8w_pkg::pos_flag_ovf] = next_irq_status[tmr8w_pkg::pos_flag_ovf] | ovf_event;
        next_irq_status[tmr8w_pkg::pos_flag_a] = next_irq_status[tmr8w_pkg::pos_flag_a] | match_a;
        next_irq_status[tmr8w_pkg::pos_flag_b] = next_irq_status[tmr8w_pkg::pos_flag_b] | match_b;
        next_irq = |(next_irq_status & next_irq_mask);
        next_pin_a = |next_mode_ctrl[tmr8w_pkg::pos_out_a +: 2];
        next_pin_b = |next_mode_ctrl[tmr8w_pkg::pos_out_b +: 2];
        next_cmp_out_a = chan_a_out;
        next_cmp_out_b = chan_b_out;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode_ctrl <= tmr8w_pkg::reset_byte;
            ctrl_b <= 4'h0;
            count_value <= tmr8w_pkg::reset_byte;
            counting_down <= 1'b0;
            irq_mask <= 3'h0;
            irq_status <= 3'h0;
            prescale <= 10'h000;
            ext_sync <= 3'h0;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            cmp_out_a <= 1'b0;
            cmp_out_b <= 1'b0;
            pin_a_override <= 1'b0;
            pin_b_override <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            mode_ctrl <= next_mode_ctrl;
            ctrl_b <= next_ctrl_b;
            count_value <= next_count_value;
            counting_down <= next_counting_down;
            irq_mask <= next_irq_mask;
            irq_status <= next_irq_status;
            prescale <= next_prescale;
            // Edges are taken from the last two stages only, never the first
            ext_sync <= {ext_sync[1:0], ext_clk_pin};
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata <= next_hrdata;
            // Registers answer at once, so the bus never stalls or fails
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            cmp_out_a <= next_cmp_out_a;
            cmp_out_b <= next_cmp_out_b;
            pin_a_override <= next_pin_a;
            pin_b_override <= next_pin_b;
            irq <= next_irq;
        end
    end
endmodule

/* verification/tmr8w_props.sv */
// Checker for the timer's bus answers, pin ownership and interrupt mask
`timescale 1ns/10ps
module tmr8w_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic cmp_out_a,
    input wire logic pin_a_override,
    input wire logic pin_b_override,
    input wire logic irq
);
    logic dp_rd, dp_wr;
    logic [7:0] dp_a, sh_mode, sh_mask;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // Shadows follow completed writes, as software sees them
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_rd <= 1'b0;
            dp_wr <= 1'b0;
            dp_a <= 8'h00;
            sh_mode <= 8'h00;
            sh_mask <= 8'h00;
        end
        else if (hready)
        begin
            dp_rd <= hsel && htrans[1] && !hwrite;
            dp_wr <= hsel && htrans[1] && hwrite;
            dp_a <= haddr[7:0];
            if (dp_wr && dp_a == 8'h30)
                sh_mode <= hwdata[7:0];
            if (dp_wr && dp_a == 8'h39)
                sh_mask <= hwdata[7:0];
        end
    end
    a_ready_high: assert property (hreadyout)
        else $error("hreadyout low");
    a_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    a_rdata_idle: assert property (!dp_rd |-> hrdata == 32'h0)
        else $error("hrdata outside read data phase");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
        else $error("hrdata upper bits set");
    a_mode_read: assert property (
        dp_rd && dp_a == 8'h30 |-> hrdata[7:0] == ($past(sh_mode) & 8'hf3))
        else $error("mode control readback wrong");
    a_override_a: assert property (
        $stable(sh_mode[7:6]) |-> pin_a_override == (sh_mode[7:6] != 2'b00))
        else $error("pin a ownership wrong");
    a_override_b: assert property (
        $stable(sh_mode[5:4]) |-> pin_b_override == (sh_mode[5:4] != 2'b00))
        else $error("pin b ownership wrong");
    a_irq_masked: assert property (
        sh_mask[2:0] == 3'h0 && $past(sh_mask[2:0]) == 3'h0 |-> !irq)
        else $error("irq with all sources masked");
    c_irq: cover property ($rose(irq));
    c_wave: cover property ($rose(cmp_out_a));
    c_mode_read: cover property (dp_rd && dp_a == 8'h30);
endmodule

/* verification/tmr8w_pin.sv */
// Port pin model: direction bit, port latch and timer override
`timescale 1ns/10ps
module tmr8w_pin (
    input wire logic dir_out,
    input wire logic port_val,
    input wire logic ovr,
    input wire logic wave,
    output logic pad
);
    // Driver off: external pull-up holds the pad
    assign pad = !dir_out ? 1'b1 : (ovr ? wave : port_val);
endmodule

/* verification/tmr8w_test.sv */
// Self-checking bench for the waveform timer
`timescale 1ns/10ps
module tmr8w_test;
    logic hclk, hresetn, hsel, hwrite, ext_pin, dir_a, port_a;
    logic hreadyout, hresp, out_a, out_b, ovr_a, ovr_b, irq, pad_a;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int miscompares, num_checks, k, c;
    logic [7:0] mc [4] = '{8'h83, 8'hc3, 8'h81, 8'hc1};
    int lo [4] = '{64, 64, 127, 127};
    int dv [4] = '{8, 64, 256, 1024};

    tmr8w_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ext_clk_pin(ext_pin), .cmp_out_a(out_a), .cmp_out_b(out_b),
        .pin_a_override(ovr_a), .pin_b_override(ovr_b), .irq(irq));
    tmr8w_pin i_pin (.dir_out(dir_a), .port_val(port_a), .ovr(ovr_a), .wave(out_a),
        .pad(pad_a));

    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic give_up();
        miscompares++;
        print_verdict();
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_span(input int got, input int l, input int h);
        num_checks++;
        if (got < l || got > h)
        begin
            miscompares++;
            $display("CHECK FAILED %0t got %h exp %h..%h", $time, got, l, h);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (hreadyout !== 1'b1)
        begin
            @(posedge hclk);
            n++;
            if (n > 50)
                give_up();
        end
    endtask
    // Address phase, then data phase; read data taken at its closing edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge hclk);
        wait_ready();
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        wait_ready();
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check_val(rd, exp);
    endtask
    // Cycles until the chosen output shows lvl, bounded
    task automatic wait_o(input logic b, input logic lvl, output int n);
        n = 0;
        while ((b ? out_b : out_a) !== lvl)
        begin
            @(posedge hclk);
            n++;
            if (n > 700)
                give_up();
        end
    endtask

    initial
    begin
        {hresetn, hwrite, ext_pin, dir_a, port_a} = 5'h00;
        hsel = 1'b1;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'b00;
        miscompares = 0;
        num_checks = 0;
        cyc(10);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(8'h30, 32'h0);
        wr(8'h30, 32'hff);
        rdc(8'h30, 32'hf3);
        rdc(8'h20, 32'h0);
        wr(8'h30, 32'h40);
        check_val(pad_a, 1'b1);
        dir_a <= 1'b1;
        cyc(3);
        check_val({ovr_a, ovr_b}, 2'b10);
        check_val(pad_a, 1'b0);
        wr(8'h36, 32'h10);
        wr(8'h3c, 32'h20);
        wr(8'h30, 32'h70);
        wr(8'h33, 32'h1);
        wait_o(1'b1, 1'b1, k);
        wait_o(1'b0, 1'b0, k);
        wait_o(1'b0, 1'b1, k);
        check_span(k, 255, 257);
        wr(8'h30, 32'ha0);
        wait_o(1'b1, 1'b0, k);
        wr(8'h33, 32'h0);
        rdc(8'h38, 32'h7);
        wr(8'h38, 32'h7);
        rdc(8'h38, 32'h0);
        wr(8'h39, 32'h1);
        check_val(irq, 1'b0);
        wr(8'h32, 32'hfe);
        wr(8'h33, 32'h1);
        cyc(6);
        check_val(irq, 1'b1);
        wr(8'h33, 32'h0);
        wr(8'h39, 32'h0);
        cyc(2);
        check_val(irq, 1'b0);
        wr(8'h39, 32'h1);
        cyc(2);
        check_val(irq, 1'b1);
        wr(8'h38, 32'h1);
        cyc(2);
        check_val(irq, 1'b0);
        // Uneven read spacing so every count phase is sampled
        for (int j = 0; j < 2; j++)
        begin
            wr(8'h33, 32'h0);
            wr(8'h32, 32'h0);
            wr(8'h36, 32'h5);
            wr(8'h30, j ? 32'h3 : 32'h2);
            wr(8'h33, j ? 32'h9 : 32'h1);
            cyc(40);
            c = 0;
            for (int i = 0; i < 12; i++)
            begin
                bus(1'b0, 8'h32, 32'h0);
                if (int'(rd[7:0]) > c)
                    c = int'(rd[7:0]);
                if (i % 2)
                    cyc(1);
            end
            check_span(c, 5, 5);
        end
        for (int j = 0; j < 4; j++)
        begin
            wr(8'h33, 32'h0);
            wr(8'h30, {24'h0, mc[j]});
            wr(8'h36, 32'h40);
            wr(8'h32, 32'h0);
            wr(8'h33, 32'h1);
            cyc(600);
            wait_o(1'b0, mc[j][6], k);
            wait_o(1'b0, !mc[j][6], k);
            wait_o(1'b0, mc[j][6], k);
            check_span(k, lo[j], lo[j] + 2);
        end
        // Compare at top: fast and phase non-inverting both stay high
        for (int j = 0; j < 2; j++)
        begin
            wr(8'h33, 32'h0);
            wr(8'h36, 32'hff);
            wr(8'h30, j ? 32'h81 : 32'h83);
            wr(8'h33, 32'h1);
            cyc(600);
            c = 0;
            repeat (600)
            begin
                @(posedge hclk);
                if (out_a !== 1'b1)
                    c++;
            end
            check_val(c, 0);
        end
        // Code 01 in mode 7: A toggles at top, B must hold
        wr(8'h33, 32'h0);
        wr(8'h32, 32'h0);
        wr(8'h30, 32'h53);
        wr(8'h36, 32'h20);
        wr(8'h3c, 32'h20);
        wr(8'h33, 32'h9);
        wait_o(1'b0, 1'b0, k);
        check_val(out_b, 1'b0);
        wait_o(1'b0, 1'b1, k);
        check_span(k, 33, 34);
        wr(8'h30, 32'h0);
        for (int s = 0; s < 4; s++)
        begin
            wr(8'h33, 32'h0);
            wr(8'h32, 32'h0);
            wr(8'h33, s + 2);
            cyc(1000);
            wr(8'h33, 32'h0);
            bus(1'b0, 8'h32, 32'h0);
            check_span(int'(rd[7:0]), 1000 / dv[s] - 1, 1000 / dv[s] + 2);
        end
        for (int s = 6; s < 8; s++)
        begin
            wr(8'h33, 32'h0);
            wr(8'h32, 32'h0);
            wr(8'h33, s);
            repeat (5)
            begin
                ext_pin <= 1'b1;
                cyc(6);
                ext_pin <= 1'b0;
                cyc(6);
            end
            rdc(8'h32, 32'h5);
        end
        print_verdict();
    end
endmodule

bind tmr8w_top tmr8w_props i_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .cmp_out_a, .pin_a_override,
    .pin_b_override, .irq);
